/* dv/afpr_ctrl_model.sv */
`timescale 1ns/100ps
module afpr_ctrl_model #(
	parameter int unsigned MIN_GAP = 16
) (
	// clock
	input wire logic aclk,
	// request from the bench to hold the device in reset
	input wire logic rst_req,
	// status pins as seen on the board
	input wire logic sd_pin,
	input wire logic tw_pin,
	// outputs of the controller
	output logic amp_reset_n,
	output logic volume_cut
);
	int unsigned gap_cnt = MIN_GAP;
	logic sd_q = 1'b1;
	// held low from power-up until the bench lets go
	initial amp_reset_n = 1'b0;
	initial volume_cut = 1'b0;
	always @(posedge aclk)
	begin
		sd_q <= sd_pin;
		if (sd_q && !sd_pin)
			gap_cnt <= 0;
		else if (gap_cnt < MIN_GAP)
			gap_cnt <= gap_cnt + 1;
		if (rst_req)
			amp_reset_n <= 1'b0;
		else if (gap_cnt >= MIN_GAP)
			amp_reset_n <= 1'b1;
		// cut drive on the high warning seen at tw_pin so shutdown is not reached
		if (!tw_pin)
			volume_cut <= 1'b1;
	end
endmodule // afpr_ctrl_model

/* dv/amp_fault_protection_reporting_test.sv */
`timescale 1ns/100ps
module amp_fault_protection_reporting_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = '0, araddr = '0, wstrb = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic amp_reset_n, volume_cut, rst_req = 1'b1;
	logic common_supply_uv = 0, overtemp_error = 0;
	logic temp_over_high = 0, temp_over_low = 0;
	logic [3:0] gate_drive_supply_uv = '0, bootstrap_pin_uv = '0;
	logic [3:0] overload_fault = '0, bridge_hiz, bridge_pulldown, exp_hiz;
	logic sd_o, sd_oe, tw_o, tw_oe, twl_o, twl_oe, twh_o, twh_oe;
	wire sd_pin = sd_oe ? sd_o : 1'b1;
	wire tw_pin = tw_oe ? tw_o : 1'b1;
	wire twl_pin = twl_oe ? twl_o : 1'b1;
	wire twh_pin = twh_oe ? twh_o : 1'b1;
	int error_cnt = 0, n_checks = 0, seed = 53, m, b, i;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [33:0] rexp;

	always #2 aclk = ~aclk;

	afpr_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .amp_reset_n(amp_reset_n),
		.common_supply_uv(common_supply_uv),
		.gate_drive_supply_uv(gate_drive_supply_uv),
		.bootstrap_pin_uv(bootstrap_pin_uv), .overload_fault(overload_fault),
		.overtemp_error(overtemp_error), .temp_over_high(temp_over_high),
		.temp_over_low(temp_over_low), .bridge_hiz(bridge_hiz),
		.bridge_pulldown(bridge_pulldown), .shutdown_flag_n_i(sd_pin),
		.shutdown_flag_n_o(sd_o), .shutdown_flag_n_oe(sd_oe),
		.thermal_warning_n_i(tw_pin), .thermal_warning_n_o(tw_o),
		.thermal_warning_n_oe(tw_oe), .thermal_warning_low_n_i(twl_pin),
		.thermal_warning_low_n_o(twl_o), .thermal_warning_low_n_oe(twl_oe),
		.thermal_warning_high_n_i(twh_pin),
		.thermal_warning_high_n_o(twh_o), .thermal_warning_high_n_oe(twh_oe));

	afpr_ctrl_model u_ctrl (.aclk(aclk), .rst_req(rst_req), .sd_pin(sd_pin),
		.tw_pin(tw_pin), .amp_reset_n(amp_reset_n), .volume_cut(volume_cut));

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task tmo;
		error_cnt++;
		$display("Error handshake expected done seen timeout");
		wrap_up();
	endtask

	// async inputs need sync plus output register, so 5 edges is ample
	task settle;
		repeat (5) @(posedge aclk);
		#1;
	endtask

	task pins(input logic [3:0] hiz, input logic sd, twl, twh);
		chk("bridge_hiz", 32'(hiz), 32'(bridge_hiz));
		chk("sd_pin", 32'(sd), 32'(sd_pin));
		chk("twl_pin", 32'(twl), 32'(twl_pin));
		chk("twh_pin", 32'(twh), 32'(twh_pin));
		chk("tw_pin", 32'(twh), 32'(tw_pin));
	endtask

	task axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bq.push_back(er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 64; i++)
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
				break;
		end
		bready <= 1'b0;
		if (i == 64)
			tmo();
	endtask

	task axi_rd(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		rq.push_back({er, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 64; i++)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
				break;
		end
		rready <= 1'b0;
		if (i == 64)
			tmo();
	endtask

	task rst_off;
		@(posedge aclk);
		rst_req <= 1'b0;
		for (i = 0; i < 200 && amp_reset_n !== 1'b1; i++)
			@(posedge aclk);
		if (i == 200)
			tmo();
		settle();
	endtask

	task pulse_rst(input logic [3:0] pd);
		@(posedge aclk);
		rst_req <= 1'b1;
		settle();
		pins(4'hf, 1'b1, 1'b1, 1'b1);
		chk("pulldown", 32'(pd), 32'(bridge_pulldown));
		rst_off();
		pins(4'h0, 1'b1, 1'b1, 1'b1);
	endtask

	// bus results are compared as they appear, oldest expectation first
	always @(posedge aclk)
	begin
		if (bvalid && bready)
			chk("bresp", 32'(bq.size() ? bq.pop_front() : 2'bxx), 32'(bresp));
		if (rvalid && rready)
		begin
			rexp = rq.size() ? rq.pop_front() : 34'bx;
			chk("rresp", 32'(rexp[33:32]), 32'(rresp));
			chk("rdata", rexp[31:0], rdata);
		end
	end

	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		overload_fault <= 4'h1;
		settle();
		pins(4'hf, 1'b1, 1'b1, 1'b1);
		chk("pulldown", 32'hf, 32'(bridge_pulldown));
		@(posedge aclk);
		overload_fault <= 4'h0;
		settle();
		axi_rd(afpr_pkg::CTRL_OFFSET, 32'h0, afpr_pkg::RESP_OKAY);
		axi_wr(4'h8, $random(seed), afpr_pkg::RESP_SLVERR);
		axi_rd(4'h8, 32'h0, afpr_pkg::RESP_SLVERR);
		axi_wr(afpr_pkg::STATUS_OFFSET, $random(seed), afpr_pkg::RESP_OKAY);
		axi_wr(afpr_pkg::CTRL_OFFSET, $random(seed) | 32'h3,
			afpr_pkg::RESP_OKAY);
		axi_rd(afpr_pkg::CTRL_OFFSET, 32'h0, afpr_pkg::RESP_OKAY);
		$display("test reset pin and registers done");
		rst_off();
		pins(4'h0, 1'b1, 1'b1, 1'b1);
		chk("pulldown", 32'h0, 32'(bridge_pulldown));
		axi_rd(afpr_pkg::STATUS_OFFSET, 32'h20000, afpr_pkg::RESP_OKAY);
		@(posedge aclk);
		common_supply_uv <= 1'b1;
		settle();
		pins(4'hf, 1'b0, 1'b1, 1'b1);
		@(posedge aclk);
		common_supply_uv <= 1'b0;
		gate_drive_supply_uv <= 4'h1 << ($unsigned($random(seed)) % 4);
		settle();
		pins(4'hf, 1'b0, 1'b1, 1'b1);
		@(posedge aclk);
		gate_drive_supply_uv <= 4'h0;
		bootstrap_pin_uv <= 4'h1 << ($unsigned($random(seed)) % 4);
		settle();
		pins(bootstrap_pin_uv, 1'b0, 1'b1, 1'b1);
		@(posedge aclk);
		bootstrap_pin_uv <= 4'h0;
		settle();
		pins(4'h0, 1'b1, 1'b1, 1'b1);
		$display("test supplies done");
		for (m = 0; m < 3; m++)
			for (b = 0; b < 4; b++)
			begin
				axi_wr(afpr_pkg::CTRL_OFFSET, 32'(m), afpr_pkg::RESP_OKAY);
				@(posedge aclk);
				overload_fault <= 4'h1 << b;
				settle();
				@(posedge aclk);
				overload_fault <= 4'h0;
				settle();
				exp_hiz = (m == 1) ? 4'hf : ((b < 2) ? 4'h3 : 4'hc);
				pins(exp_hiz, 1'b0, 1'b1, 1'b1);
				pulse_rst((m == 2) ? 4'h0 : 4'hf);
			end
		$display("test overload mapping done");
		@(posedge aclk);
		temp_over_low <= 1'b1;
		settle();
		pins(4'h0, 1'b1, 1'b0, 1'b1);
		@(posedge aclk);
		temp_over_high <= 1'b1;
		settle();
		pins(4'h0, 1'b1, 1'b0, 1'b0);
		chk("volume_cut", 32'h1, 32'(volume_cut));
		@(posedge aclk);
		temp_over_low <= 1'b0;
		temp_over_high <= 1'b0;
		overtemp_error <= 1'b1;
		settle();
		@(posedge aclk);
		overtemp_error <= 1'b0;
		settle();
		pins(4'hf, 1'b0, 1'b0, 1'b0);
		axi_rd(afpr_pkg::STATUS_OFFSET, 32'h3c10f, afpr_pkg::RESP_OKAY);
		pulse_rst(4'h0);
		$display("test temperature done");
		repeat (4) @(posedge aclk);
		chk("queues", 32'h0, 32'(bq.size() + rq.size()));
		wrap_up();
	end
endmodule // amp_fault_protection_reporting_test

/* rtl/afpr_axil.sv */
`timescale 1ns/100ps
module afpr_axil #(
	parameter int unsigned ADDR_W = 4
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write channels
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register file side
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);

	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic awready_next, wready_next, bvalid_next;
	logic [1:0] bresp_next, rresp_next;
	logic arready_next, rvalid_next;
	logic [31:0] rdata_next;

	assign wr_addr = aw_addr_reg;
	assign wr_data = w_data_reg;
	assign wr_strb = w_strb_reg;
	assign rd_addr = araddr;

	always_comb
	begin
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next = w_held_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid;
		bresp_next = bresp;
		wr_en = 1'b0;
		if (awvalid && awready)
		begin
			aw_held_next = 1'b1;
			aw_addr_next = awaddr;
		end
		if (wvalid && wready)
		begin
			w_held_next = 1'b1;
			w_data_next = wdata;
			w_strb_next = wstrb;
		end
		if (bvalid && bready)
			bvalid_next = 1'b0;
		if (aw_held_reg && w_held_reg && !bvalid)
		begin
			wr_en = 1'b1;
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_err ? afpr_pkg::RESP_SLVERR : afpr_pkg::RESP_OKAY;
		end
		// no new address or data while a response waits
		awready_next = !aw_held_next && !bvalid_next;
		wready_next = !w_held_next && !bvalid_next;
		rvalid_next = rvalid;
		rdata_next = rdata;
		rresp_next = rresp;
		if (rvalid && rready)
			rvalid_next = 1'b0;
		if (arvalid && arready)
		begin
			rvalid_next = 1'b1;
			rdata_next = rd_data;
			rresp_next = rd_err ? afpr_pkg::RESP_SLVERR : afpr_pkg::RESP_OKAY;
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= 2'h0;
		end
		else
		begin
			aw_held_reg <= aw_held_next;
			aw_addr_reg <= aw_addr_next;
			w_held_reg <= w_held_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			awready <= awready_next;
			wready <= wready_next;
			bvalid <= bvalid_next;
			bresp <= bresp_next;
			arready <= arready_next;
			rvalid <= rvalid_next;
			rdata <= rdata_next;
			rresp <= rresp_next;
		end
	end

endmodule // afpr_axil

/* rtl/afpr_pkg.sv */
package afpr_pkg;

	// register byte offsets
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;

	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W = 2;

	// status register fields
	localparam int STAT_BRIDGE_OFF_LSB = 0;
	localparam int STAT_OVERLOAD_LSB = 4;
	localparam int STAT_OVERTEMP_BIT = 8;
	localparam int STAT_UNDERVOLT_BIT = 9;
	localparam int STAT_BOOT_UV_LSB = 10;
	localparam int STAT_SHUTDOWN_BIT = 14;
	localparam int STAT_WARN_HIGH_BIT = 15;
	localparam int STAT_WARN_LOW_BIT = 16;
	localparam int STAT_RESET_PIN_BIT = 17;

	// output configurations
	typedef enum logic [1:0] {
		MODE_BRIDGE_TIED = 2'h0,
		MODE_PARALLEL_BRIDGE = 2'h1,
		MODE_SINGLE_ENDED = 2'h2
	} afpr_mode_type;

	localparam afpr_mode_type MODE_RESET = MODE_BRIDGE_TIED;
	localparam logic [1:0] MODE_ILLEGAL = 2'h3;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// number of half-bridges, a to d
	localparam int BRIDGES = 4;

endpackage

/* rtl/afpr_sync.sv */
`timescale 1ns/100ps
module afpr_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	generate
		for (genvar i = 0; i < WIDTH; i++)
		begin : g_bit
			// meta_reg feeds only the second stage
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					meta_reg[i] <= RST_VAL[i];
					sync_out[i] <= RST_VAL[i];
				end
				else
				begin
					meta_reg[i] <= async_in[i];
					sync_out[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

endmodule // afpr_sync

/* rtl/afpr_top.sv */
// Summary of operation
// - half-bridges stay high impedance until gate-drive and common supplies pass undervoltage.
// - reset low during power-up enables weak pulldown on each half-bridge output (the code enables none while the mode is single-ended).
// - normal operation continues while both supplies stay above undervoltage threshold.
// - shutdown flag and thermal warnings are active-low open-drain outputs.
// - shutdown flag goes low whenever a fault shuts the power stage down.
// - high and single warnings above 125 C, low warning above 100 C.
// - normal operation shows shutdown flag and both warnings high.
// - overtemperature error shows shutdown with both warnings low.
// - reset low forces the shutdown flag high regardless of faults.
// - a detected fault puts the stage in high impedance and flags shutdown.
// - recovery is automatic except overload and overtemperature, which stay latched.
// - bridge-tied and single-ended turn off pairs; parallel mode turns off all four.
// - bootstrap undervoltage shuts down only its own half-bridge.
// - overtemperature error latches and clears only while reset is asserted.
// - reset low forces all four half-bridges into high impedance.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module afpr_top #(
	parameter int unsigned ADDR_W = 4
) (
	// clock and bus reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// device reset pin and fault sensors, asynchronous
	input wire logic amp_reset_n,
	input wire logic common_supply_uv,
	input wire logic [3:0] gate_drive_supply_uv,
	input wire logic [3:0] bootstrap_pin_uv,
	input wire logic [3:0] overload_fault,
	input wire logic overtemp_error,
	input wire logic temp_over_high,
	input wire logic temp_over_low,
	// half-bridge control, a at bit 0
	output logic [3:0] bridge_hiz,
	output logic [3:0] bridge_pulldown,
	// open-drain status pins
	input wire logic shutdown_flag_n_i,
	output logic shutdown_flag_n_o,
	output logic shutdown_flag_n_oe,
	input wire logic thermal_warning_n_i,
	output logic thermal_warning_n_o,
	output logic thermal_warning_n_oe,
	input wire logic thermal_warning_low_n_i,
	output logic thermal_warning_low_n_o,
	output logic thermal_warning_low_n_oe,
	input wire logic thermal_warning_high_n_i,
	output logic thermal_warning_high_n_o,
	output logic thermal_warning_high_n_oe
);

	localparam int SYNC_W = 17;

	// offsets are four bits wide, so the decode cannot use more
	initial
	begin
		if (ADDR_W < 3 || ADDR_W > 4)
			$error("afpr_top: ADDR_W must be 3 or 4 for register map");
	end

	logic [SYNC_W-1:0] pins_async, pins_sync;
	logic rst_pin, supply_uv, ote_s, t_high, t_low;
	logic [3:0] ovl_s, bst_uv;

	// reset pin resets to asserted so the stage starts safe
	assign pins_async = {amp_reset_n, common_supply_uv, gate_drive_supply_uv,
		bootstrap_pin_uv, overload_fault, overtemp_error, temp_over_high,
		temp_over_low};

	afpr_sync #(
		.WIDTH(SYNC_W),
		.RST_VAL(17'h0)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	assign rst_pin = pins_sync[16];
	assign supply_uv = pins_sync[15] | (|pins_sync[14:11]);
	assign bst_uv = pins_sync[10:7];
	assign ovl_s = pins_sync[6:3];
	assign ote_s = pins_sync[2];
	assign t_high = pins_sync[1];
	assign t_low = pins_sync[0];

	// register file
	logic wr_en, wr_err, rd_err;
	logic [ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	afpr_pkg::afpr_mode_type mode_reg, mode_next;

	afpr_axil #(
		.ADDR_W(ADDR_W)
	) u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// fault state
	logic [3:0] ovl_reg, ovl_next, group_off, off_next, pd_next;
	logic ote_reg, ote_next, fault_any, sd_next, wh_next, wl_next;
	logic [3:0] hiz_reg, pd_reg;
	logic sd_oe_reg, wh_oe_reg, wl_oe_reg;

	always_comb
	begin
		// hardware set wins over the reset-pin clear
		ovl_next = ovl_s | (ovl_reg & {4{rst_pin}});
		ote_next = ote_s | (ote_reg & rst_pin);
		if (mode_reg == afpr_pkg::MODE_PARALLEL_BRIDGE)
			group_off = {4{|ovl_next}};
		else
			group_off = {{2{|ovl_next[3:2]}}, {2{|ovl_next[1:0]}}};
		// bootstrap undervoltage stays local to its bridge
		off_next = group_off | bst_uv;
		if (supply_uv || ote_next)
			off_next = 4'hf;
		fault_any = |off_next;
		if (!rst_pin)
			off_next = 4'hf;
		// single-ended outputs get no pulldown
		pd_next = 4'h0;
		if (!rst_pin && mode_reg != afpr_pkg::MODE_SINGLE_ENDED)
			pd_next = 4'hf;
		sd_next = fault_any && rst_pin;
		wh_next = t_high || ote_next;
		wl_next = t_low || ote_next;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ovl_reg <= 4'h0;
			ote_reg <= 1'b0;
			hiz_reg <= 4'hf;
			pd_reg <= 4'h0;
			sd_oe_reg <= 1'b0;
			wh_oe_reg <= 1'b0;
			wl_oe_reg <= 1'b0;
		end
		else
		begin
			ovl_reg <= ovl_next;
			ote_reg <= ote_next;
			hiz_reg <= off_next;
			pd_reg <= pd_next;
			sd_oe_reg <= sd_next;
			wh_oe_reg <= wh_next;
			wl_oe_reg <= wl_next;
		end
	end

	// open-drain: the pin is only ever pulled low
	assign bridge_hiz = hiz_reg;
	assign bridge_pulldown = pd_reg;
	assign shutdown_flag_n_oe = sd_oe_reg;
	assign thermal_warning_n_oe = wh_oe_reg;
	assign thermal_warning_high_n_oe = wh_oe_reg;
	assign thermal_warning_low_n_oe = wl_oe_reg;
	logic od_low_reg;
	always_ff @(posedge aclk)
	begin
		od_low_reg <= 1'b0;
	end
	assign shutdown_flag_n_o = od_low_reg;
	assign thermal_warning_n_o = od_low_reg;
	assign thermal_warning_high_n_o = od_low_reg;
	assign thermal_warning_low_n_o = od_low_reg;

	// control register and decode
	always_comb
	begin
		mode_next = mode_reg;
		wr_err = 1'b0;
		if (wr_addr == afpr_pkg::CTRL_OFFSET[ADDR_W-1:0])
		begin
			// the unused code is refused, mode is kept
			if (wr_en && wr_strb[0] && wr_data[1:0] != afpr_pkg::MODE_ILLEGAL)
				mode_next = afpr_pkg::afpr_mode_type'(wr_data[1:0]);
		end
		else if (wr_addr == afpr_pkg::STATUS_OFFSET[ADDR_W-1:0])
			wr_err = 1'b0;
		else
			wr_err = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_reg <= afpr_pkg::MODE_RESET;
		else
			mode_reg <= mode_next;
	end

	always_comb
	begin
		rd_data = 32'h0;
		rd_err = 1'b0;
		if (rd_addr == afpr_pkg::CTRL_OFFSET[ADDR_W-1:0])
			rd_data[afpr_pkg::CTRL_MODE_LSB +: afpr_pkg::CTRL_MODE_W] = mode_reg;
		else if (rd_addr == afpr_pkg::STATUS_OFFSET[ADDR_W-1:0])
		begin
			rd_data[afpr_pkg::STAT_BRIDGE_OFF_LSB +: 4] = hiz_reg;
			rd_data[afpr_pkg::STAT_OVERLOAD_LSB +: 4] = ovl_reg;
			rd_data[afpr_pkg::STAT_OVERTEMP_BIT] = ote_reg;
			rd_data[afpr_pkg::STAT_UNDERVOLT_BIT] = supply_uv;
			rd_data[afpr_pkg::STAT_BOOT_UV_LSB +: 4] = bst_uv;
			rd_data[afpr_pkg::STAT_SHUTDOWN_BIT] = sd_oe_reg;
			rd_data[afpr_pkg::STAT_WARN_HIGH_BIT] = wh_oe_reg;
			rd_data[afpr_pkg::STAT_WARN_LOW_BIT] = wl_oe_reg;
			rd_data[afpr_pkg::STAT_RESET_PIN_BIT] = rst_pin;
		end
		else
			rd_err = 1'b1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_reset_all_hiz: assert property (!rst_pin |=> bridge_hiz == 4'hf)
		else $error("reset pin low but a bridge is driven");
	a_reset_sd_high: assert property (!rst_pin |=> !shutdown_flag_n_oe)
		else $error("shutdown flag pulled low during reset");
	a_reset_pulldown: assert property (!rst_pin &&
		mode_reg != afpr_pkg::MODE_SINGLE_ENDED |=> bridge_pulldown == 4'hf)
		else $error("pulldown missing while reset low");
	a_supply_uv_off: assert property (supply_uv && rst_pin
		|=> bridge_hiz == 4'hf && shutdown_flag_n_oe)
		else $error("supply undervoltage did not shut down");
	a_ote_latch_hold: assert property (ote_reg && rst_pin |=> ote_reg [*1]
		##1 (ote_reg || !$past(rst_pin)))
		else $error("overtemperature latch lost without reset");
	a_ote_latch_clear: assert property (ote_reg && !rst_pin && !ote_s
		|=> !ote_reg)
		else $error("overtemperature latch not cleared by reset");
	a_warn_levels: assert property ($past(t_high) && $past(t_low) |->
		thermal_warning_high_n_oe && thermal_warning_n_oe
		&& thermal_warning_low_n_oe)
		else $error("thermal warnings not asserted");
	a_ote_warns: assert property (ote_reg && rst_pin |=> shutdown_flag_n_oe
		&& thermal_warning_low_n_oe && thermal_warning_high_n_oe)
		else $error("overtemperature not shown on warnings");
	a_sd_cause: assert property (shutdown_flag_n_oe |->
		$past(rst_pin) && $past(fault_any))
		else $error("shutdown flag without a fault");
	a_normal_quiet: assert property (rst_pin && !fault_any && !t_low
		&& !t_high |=> !shutdown_flag_n_oe && !thermal_warning_low_n_oe
		&& !thermal_warning_high_n_oe && bridge_hiz == 4'h0)
		else $error("normal operation not reported");
	a_parallel_bridge_mode_all_off: assert property (mode_reg ==
		afpr_pkg::MODE_PARALLEL_BRIDGE && ovl_s[0] |=> bridge_hiz == 4'hf)
		else $error("parallel mode overload left a bridge on");
	a_pair_off: assert property (mode_reg != afpr_pkg::MODE_PARALLEL_BRIDGE
		&& ovl_s[2] |=> bridge_hiz[3])
		else $error("pair partner not turned off");
	a_boot_local: assert property (rst_pin && bst_uv == 4'h1 && !supply_uv
		&& !ote_next && ovl_next == 4'h0 |=> bridge_hiz == 4'h1)
		else $error("bootstrap undervoltage not local");

	c_overload: cover property (ovl_reg != 4'h0 ##1 !rst_pin ##1 rst_pin);
	c_overtemp: cover property (ote_reg && shutdown_flag_n_oe);
	c_uv_recover: cover property (supply_uv ##1 !supply_uv ##1
		bridge_hiz == 4'h0);
	c_parallel_bridge_mode: cover property (mode_reg == afpr_pkg::MODE_PARALLEL_BRIDGE
		&& bridge_hiz == 4'hf && rst_pin);

endmodule // afpr_top
